// >>> pkg/acc_pkg.sv
// Package for the analog comparator control block.
// Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock domain.
package acc_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [3:0] STATUS_CONTROL_OFFS = 4'h0;   // Status and control byte.
   localparam logic [3:0] IRQ_STATUS_OFFS     = 4'h4;   // Sticky event status.
   localparam logic [3:0] IRQ_ENABLE_OFFS     = 4'h8;   // Event enable.
   localparam logic [3:0] IRQ_CLEAR_OFFS      = 4'hC;   // Write one to clear status.

   // -----------------------------------------------------------------
   // Field positions of the status and control byte
   // -----------------------------------------------------------------
   localparam int unsigned ENABLE_BIT   = 7;
   localparam int unsigned REFSEL_BIT   = 6;
   localparam int unsigned FLAG_BIT     = 5;
   localparam int unsigned IRQEN_BIT    = 4;
   localparam int unsigned OUTVAL_BIT   = 3;
   localparam int unsigned PINEN_BIT    = 2;
   localparam int unsigned EDGE_LSB     = 0;

   localparam logic [7:0] CONTROL_RESET = 8'h00;   // Whole byte after reset.
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // Event edge selection codes.
   typedef enum logic [1:0] {
      EDGE_FALL_A = 2'b00,
      EDGE_RISE   = 2'b01,
      EDGE_FALL_B = 2'b10,
      EDGE_BOTH   = 2'b11
   } acc_edge_t;

   // Analog-facing signals that travel together.
   typedef struct packed {
      logic enable;        // Powers the comparator core.
      logic reference_sel; // One selects the internal reference.
   } acc_analog_ctl_t;

endpackage

// >>> hw/acc_edge_detect.sv
// Synchroniser and edge detector for the raw comparator output.
// Assumes the raw output is asynchronous to aclk.
`timescale 1ns/1ns
module acc_edge_detect (
   input  wire logic             aclk,      // Bus clock.
   input  wire logic             aresetn,   // Synchronous reset, active low.
   input  wire logic             raw_in,    // Asynchronous comparator output.
   input  wire logic             enable,    // Comparator enabled.
   input  wire acc_pkg::acc_edge_t edge_sel, // Selected event edge.
   output logic                  level_q,   // Synchronised level.
   output logic                  event_q    // One-cycle event pulse.
);

   logic meta_q;
   logic prev_q;
   logic rise;
   logic fall;
   logic hit;

   // -----------------------------------------------------------------
   // Edge decoding
   // -----------------------------------------------------------------
   // Edges are taken between the settled level and its previous value only.
   assign rise = level_q & ~prev_q;
   assign fall = ~level_q & prev_q;
   assign hit  = (edge_sel == acc_pkg::EDGE_RISE) ? rise :
                 (edge_sel == acc_pkg::EDGE_BOTH) ? (rise | fall) : fall;

   // Two-flop synchroniser; the first flop feeds only the second.
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         meta_q  <= 1'b0;
         level_q <= 1'b0;
         prev_q  <= 1'b0;
         event_q <= 1'b0;
      end else begin
         meta_q  <= raw_in;
         level_q <= meta_q;
         prev_q  <= level_q;
         event_q <= hit;
      end
   end

endmodule // acc_edge_detect

// >>> hw/acc_comparator_control.sv
// Control, status and bus slave for an analog comparator.
// Assumes an analog core outside that compares its inputs and returns a raw level.
//
// Contract
// - Bit 7 turns the comparator on when set and off when clear.
// - Bit 6 picks the external pin when clear and the internal reference when set.
// - The event flag in bit 5 sets on each compare event of the chosen kind.
// - Writing one to bit 5 clears the flag and writing zero leaves it.
// - With bit 4 set the interrupt is requested while the flag is set.
// - Bit 3 reads the present comparator output and ignores writes.
// - Bit 3 resets to zero and reads zero while the comparator is off.
// - Bit 2 drives the output onto the pin, only while the comparator is on.
// - Edge field 00 falling, 01 rising, 10 falling, 11 either edge.
// - The core output is high when the chosen plus input exceeds the minus input.
// - An enabled comparator keeps working in wait and its interrupt wakes the core.
// - In stop it keeps comparing, driving its pin, flagging and waking.
// - Leaving stop through reset returns everything to the reset state.
// - In background debug the logic runs exactly as normal.
// - All control and status sit in one eight-bit register; the code adds event status, enable and clear registers at 4h4, 4h8 and 4hC.
`timescale 1ns/1ns
module acc_comparator_control (
   input  wire logic                   aclk,          // Bus clock, 125 MHz.
   input  wire logic                   aresetn,       // Synchronous reset, active low.
   input  wire logic [3:0]             s_axi_awaddr,  // Write address.
   input  wire logic                   s_axi_awvalid, // Write address valid.
   output logic                        s_axi_awready, // Write address ready.
   input  wire logic [31:0]            s_axi_wdata,   // Write data.
   input  wire logic [3:0]             s_axi_wstrb,   // Write byte strobes.
   input  wire logic                   s_axi_wvalid,  // Write data valid.
   output logic                        s_axi_wready,  // Write data ready.
   output logic [1:0]                  s_axi_bresp,   // Write response.
   output logic                        s_axi_bvalid,  // Write response valid.
   input  wire logic                   s_axi_bready,  // Write response ready.
   input  wire logic [3:0]             s_axi_araddr,  // Read address.
   input  wire logic                   s_axi_arvalid, // Read address valid.
   output logic                        s_axi_arready, // Read address ready.
   output logic [31:0]                 s_axi_rdata,   // Read data.
   output logic [1:0]                  s_axi_rresp,   // Read response.
   output logic                        s_axi_rvalid,  // Read data valid.
   input  wire logic                   s_axi_rready,  // Read data ready.
   input  wire logic                   comparator_raw, // Raw core output, asynchronous.
   output acc_pkg::acc_analog_ctl_t    analog_ctl_q,  // Enable and reference select.
   output logic                        comparator_output_pin_o,  // Pin output level.
   output logic                        comparator_output_pin_oe, // Pin output enable.
   output logic                        irq_q          // Level interrupt request.
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic       enable_q, refsel_q, flag_q, irqen_q, pinen_q;
   logic [1:0] edge_q;
   logic       level_q;
   logic       event_q;
   logic       evt_sticky_q;
   logic       evt_en_q;
   logic       aw_q, w_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // -----------------------------------------------------------------
   // Edge detection of the comparator output
   // -----------------------------------------------------------------
   // The analog core itself performs the plus/minus comparison.
   acc_edge_detect i_acc_edge_detect (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .raw_in   (comparator_raw),
      .enable   (enable_q),
      .edge_sel (acc_pkg::acc_edge_t'(edge_q)),
      .level_q  (level_q),
      .event_q  (event_q)
   );

   // -----------------------------------------------------------------
   // Write channel decode
   // -----------------------------------------------------------------
   // Address and data are latched separately and joined once both are held.
   logic wr_fire, wr_ok, wr_ctl, wr_en, wr_clr;
   logic [7:0] wbyte;
   assign wr_fire = aw_q && w_q && !s_axi_bvalid;
   assign wr_ok   = awaddr_q[1:0] == 2'h0 &&
                    (awaddr_q == acc_pkg::STATUS_CONTROL_OFFS ||
                     awaddr_q == acc_pkg::IRQ_STATUS_OFFS ||
                     awaddr_q == acc_pkg::IRQ_ENABLE_OFFS ||
                     awaddr_q == acc_pkg::IRQ_CLEAR_OFFS);
   assign wbyte   = wdata_q[7:0];
   assign wr_ctl  = wr_fire && wstrb_q[0] && awaddr_q == acc_pkg::STATUS_CONTROL_OFFS;
   assign wr_en   = wr_fire && wstrb_q[0] && awaddr_q == acc_pkg::IRQ_ENABLE_OFFS;
   assign wr_clr  = wr_fire && wstrb_q[0] && awaddr_q == acc_pkg::IRQ_CLEAR_OFFS;

   // Next hold state of each write channel; the ready outputs are registered
   // copies of its inverse, so they stay straight from a flip-flop.
   logic aw_d, w_d;
   assign aw_d = aw_q ? !wr_fire : s_axi_awvalid;
   assign w_d  = w_q ? !wr_fire : s_axi_wvalid;

   // Address and data holding stages.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         awaddr_q <= 4'h0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else begin
         s_axi_awready <= !aw_d;
         s_axi_wready  <= !w_d;
         if (s_axi_awvalid && !aw_q) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_q) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_q <= 1'b0;
         end
      end
   end

   // Write response.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= acc_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Status and control byte
   // -----------------------------------------------------------------
   // The synchronous reset covers reset-exit from stop as well.
   // No gating by wait, stop or debug state exists here.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {enable_q, refsel_q}  <= acc_pkg::CONTROL_RESET[7:6];
         {irqen_q, pinen_q}    <= {acc_pkg::CONTROL_RESET[4], acc_pkg::CONTROL_RESET[2]};
         edge_q                <= acc_pkg::CONTROL_RESET[1:0];
      end else if (wr_ctl) begin
         enable_q <= wbyte[acc_pkg::ENABLE_BIT];
         refsel_q <= wbyte[acc_pkg::REFSEL_BIT];
         irqen_q  <= wbyte[acc_pkg::IRQEN_BIT];
         pinen_q  <= wbyte[acc_pkg::PINEN_BIT];
         edge_q   <= wbyte[acc_pkg::EDGE_LSB +: 2];
      end
   end

   // Event flag: a new event wins over a clear in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= acc_pkg::CONTROL_RESET[5];
      end else if (event_q) begin
         flag_q <= 1'b1;
      end else if (wr_ctl && wbyte[acc_pkg::FLAG_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   // Sticky event status with enable and write-one clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_sticky_q <= 1'b0;
         evt_en_q     <= 1'b0;
      end else begin
         if (event_q) begin
            evt_sticky_q <= 1'b1;
         end else if (wr_clr && wbyte[0]) begin
            evt_sticky_q <= 1'b0;
         end
         if (wr_en) begin
            evt_en_q <= wbyte[0];
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs to analog core, pin and interrupt
   // -----------------------------------------------------------------
   logic outval;
   logic irq_d;
   assign outval = enable_q & level_q;
   assign irq_d  = (irqen_q & flag_q) | (evt_en_q & evt_sticky_q);

   // Registered outputs; the pin enable is active low while driving.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         analog_ctl_q             <= '0;
         comparator_output_pin_o  <= 1'b0;
         comparator_output_pin_oe <= 1'b1;
         irq_q                    <= 1'b0;
      end else begin
         analog_ctl_q.enable        <= enable_q;
         analog_ctl_q.reference_sel <= refsel_q;
         comparator_output_pin_o    <= outval;
         comparator_output_pin_oe   <= !(enable_q && pinen_q);
         irq_q                      <= irq_d;
      end
   end

   // -----------------------------------------------------------------
   // Read channel
   // -----------------------------------------------------------------
   // The single control byte holds flag, control and live output.
   logic [7:0]  ctl_byte;
   logic [31:0] rd_word;
   logic        rd_ok;
   assign ctl_byte = {enable_q, refsel_q, flag_q, irqen_q, outval, pinen_q, edge_q};
   assign rd_ok    = s_axi_araddr[1:0] == 2'h0 &&
                     (s_axi_araddr == acc_pkg::STATUS_CONTROL_OFFS ||
                      s_axi_araddr == acc_pkg::IRQ_STATUS_OFFS ||
                      s_axi_araddr == acc_pkg::IRQ_ENABLE_OFFS ||
                      s_axi_araddr == acc_pkg::IRQ_CLEAR_OFFS);
   assign rd_word  = (s_axi_araddr == acc_pkg::STATUS_CONTROL_OFFS) ? {24'h000000, ctl_byte} :
                     (s_axi_araddr == acc_pkg::IRQ_STATUS_OFFS) ? {31'h0, evt_sticky_q} :
                     (s_axi_araddr == acc_pkg::IRQ_ENABLE_OFFS) ? {31'h0, evt_en_q} :
                     32'h0000_0000;
   // Next read-valid state; the address ready is its registered inverse.
   logic rvalid_d;
   assign rvalid_d = s_axi_rvalid ? !s_axi_rready : s_axi_arvalid;

   // Read data register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= acc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_arready <= !rvalid_d;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
      end else begin
         s_axi_arready <= !rvalid_d;
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_flag_on_event: assert property (@(posedge aclk) disable iff (!aresetn)
      event_q |=> flag_q) else $error("flag did not set after event");
   a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ctl && wbyte[acc_pkg::FLAG_BIT] && !event_q |=> !flag_q)
      else $error("flag not cleared by write one");
   a_flag_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ctl && !wbyte[acc_pkg::FLAG_BIT] && flag_q |=> flag_q)
      else $error("flag lost on write zero");
   a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      irqen_q && flag_q |=> irq_q) else $error("irq missing");
   a_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      !irqen_q && !evt_en_q |=> !irq_q) else $error("irq without enable");
   a_out_zero_off: assert property (@(posedge aclk) disable iff (!aresetn)
      !enable_q |-> !ctl_byte[acc_pkg::OUTVAL_BIT]) else $error("output seen while off");
   a_pin_off: assert property (@(posedge aclk) disable iff (!aresetn)
      !enable_q ##1 !enable_q |-> comparator_output_pin_oe)
      else $error("pin driven while off");
   a_enable_out: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ctl |=> ##1 analog_ctl_q.enable == $past(wbyte[acc_pkg::ENABLE_BIT], 2))
      else $error("enable not forwarded");
   a_refsel_out: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ctl |=> ##1 analog_ctl_q.reference_sel == $past(wbyte[acc_pkg::REFSEL_BIT], 2))
      else $error("reference select not forwarded");
   a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid) else $error("write not answered");
   a_aw_busy: assert property (@(posedge aclk) disable iff (!aresetn)
      aw_q |-> !s_axi_awready) else $error("address ready while holding");
   a_sticky_set: assert property (@(posedge aclk) disable iff (!aresetn)
      event_q |=> evt_sticky_q) else $error("sticky status missed event");
   a_irq_drop: assert property (@(posedge aclk) disable iff (!aresetn)
      !flag_q && !(evt_en_q && evt_sticky_q) |=> !irq_q) else $error("irq without cause");
   a_pin_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      enable_q && pinen_q |=> !comparator_output_pin_oe) else $error("pin not driven");
   a_pin_level: assert property (@(posedge aclk) disable iff (!aresetn)
      enable_q |=> comparator_output_pin_o == $past(level_q)) else $error("pin level wrong");
   a_outval_live: assert property (@(posedge aclk) disable iff (!aresetn)
      enable_q |-> ctl_byte[acc_pkg::OUTVAL_BIT] == level_q) else $error("output bit stale");

   c_event_seen: cover property (@(posedge aclk) disable iff (!aresetn) event_q);
   c_irq_raised: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_q));
   c_pin_driven: cover property (@(posedge aclk) disable iff (!aresetn)
      !comparator_output_pin_oe && comparator_output_pin_o);
   c_flag_cleared: cover property (@(posedge aclk) disable iff (!aresetn)
      flag_q ##1 !flag_q);
   c_both_edges: cover property (@(posedge aclk) disable iff (!aresetn)
      event_q && edge_q == 2'h3);

endmodule // acc_comparator_control

// >>> tb/acc_analog_model.sv
// Behavioural model of the analog comparator core driven by the control block.
// Assumes the bench supplies both pin voltages in millivolts.
`timescale 1ns/1ns
module acc_analog_model #(
   parameter int SETTLE_NS  = 20,   // Core response time.
   parameter int BANDGAP_MV = 1200  // Internal reference level.
) (
   input  wire acc_pkg::acc_analog_ctl_t ctl,           // Enable and reference select.
   input  wire logic [15:0]              noninv_mv,     // Non-inverting pin voltage.
   input  wire logic [15:0]              inv_mv,        // Inverting pin voltage.
   output logic                          comparator_raw // Raw comparator level.
);
   logic [15:0] plus_mv;
   // ----------------------------------------------------------------
   // Core
   // ----------------------------------------------------------------
   // The plus input comes from the pin or from the internal reference.
   assign plus_mv = ctl.reference_sel ? 16'(BANDGAP_MV) : noninv_mv;
   // An idle core is held high, the worst case for the read-as-zero field.
   initial comparator_raw = 1'h1;
   always #(SETTLE_NS) comparator_raw = ctl.enable ? (plus_mv > inv_mv) : 1'h1;
endmodule // acc_analog_model

// >>> tb/analog_comparator_control_tb_top.sv
// Self-checking bench for the comparator control block.
// Assumes the analog core model and an AXI4-Lite master built from tasks.
`timescale 1ns/1ns
module analog_comparator_control_tb_top;
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0]  bresp, rresp, rsp;
   logic        awready, wready, bvalid, arready, rvalid, raw, pin_o, pin_oe, irq;
   logic [15:0] plus_mv = 16'h0900, minus_mv = 16'h0800;
   acc_pkg::acc_analog_ctl_t ctl;
   int          miscompares = 0, n_tests = 0;

   acc_comparator_control i_acc_comparator_control (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .comparator_raw(raw), .analog_ctl_q(ctl), .comparator_output_pin_o(pin_o),
      .comparator_output_pin_oe(pin_oe), .irq_q(irq));

   acc_analog_model i_acc_analog_model (
      .ctl(ctl), .noninv_mv(plus_mv), .inv_mv(minus_mv), .comparator_raw(raw));

   // ----------------------------------------------------------------
   // Clock and helpers
   // ----------------------------------------------------------------
   // The clock runs at 125 MHz.
   initial begin
      forever #4 aclk = ~aclk;
   end

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Address and data are offered together; each is released once taken.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid && n < 100);
      rsp = bresp;
      bready <= 1'h0;
   endtask

   task automatic rd_raw(input logic [3:0] a);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'h0;
      end while (!rvalid && n < 100);
      rd = rdata;
      rsp = rresp;
      rready <= 1'h0;
   endtask

   task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
      rd_raw(a);
      check(nm, rd, exp);
      check("rresp", rsp, acc_pkg::RESP_OKAY);
   endtask

   task automatic settle();
      repeat (12) @(posedge aclk);
   endtask

   // Pin voltages change at a clock edge, then the path is let settle.
   task automatic drive(input logic [15:0] p, input logic [15:0] m);
      @(posedge aclk);
      plus_mv  <= p;
      minus_mv <= m;
      settle();
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   // Reset, bus errors, each field, every edge code, interrupts and a second reset.
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      check("pin_oe_rst", pin_oe, 1'h1);
      check("irq_rst", irq, 1'h0);
      rd_chk("ctrl_rst", 4'h0, 32'h0);
      rd_chk("evt_en_rst", 4'h8, 32'h0);
      rd_raw(4'h2);
      check("bad_rresp", rsp, acc_pkg::RESP_SLVERR);
      check("bad_rdata", rd, 32'h0);
      wr(4'h1, 32'hFF);
      check("bad_bresp", rsp, acc_pkg::RESP_SLVERR);
      wr(4'h0, 32'h88);
      settle();
      rd_chk("enabled", 4'h0, 32'h88);
      check("ctl_on", ctl, 2'h2);
      wr(4'h0, 32'hC0);
      settle();
      rd_chk("bandgap", 4'h0, 32'hE0);
      check("ctl_ref", ctl, 2'h3);
      wr(4'h0, 32'hC0);
      rd_chk("w0_keeps", 4'h0, 32'hE0);
      wr(4'h0, 32'hE0);
      rd_chk("w1_clears", 4'h0, 32'hC0);
      for (int m = 0; m < 4; m++) begin
         drive(16'h0100, 16'h0800);
         wr(4'h0, 32'hA0 | m);
         drive(16'h0900, 16'h0800);
         rd_chk("rise", 4'h0, 32'h88 | m | {m[0], 5'h0});
         wr(4'h0, 32'hA0 | m);
         drive(16'h0100, 16'h0800);
         rd_chk("fall", 4'h0, 32'h80 | m | {m != 1, 5'h0});
      end
      wr(4'h0, 32'hB1);
      settle();
      check("irq_idle", irq, 1'h0);
      drive(16'h0900, 16'h0800);
      check("irq_set", irq, 1'h1);
      wr(4'h0, 32'h81);
      settle();
      check("irq_masked", irq, 1'h0);
      rd_chk("flag_kept", 4'h0, 32'hA9);
      rd_chk("sticky", 4'h4, 32'h1);
      wr(4'h8, 32'h1);
      settle();
      check("irq_evt", irq, 1'h1);
      rd_chk("evt_en", 4'h8, 32'h1);
      wr(4'hC, 32'h1);
      settle();
      check("irq_clr", irq, 1'h0);
      rd_chk("sticky_clr", 4'h4, 32'h0);
      rd_chk("clr_reads0", 4'hC, 32'h0);
      wr(4'h0, 32'hA5);
      settle();
      check("pin_oe_on", pin_oe, 1'h0);
      check("pin_level", pin_o, 1'h1);
      wr(4'h0, 32'h24);
      repeat (2) settle();
      check("pin_oe_off", pin_oe, 1'h1);
      check("ctl_off", ctl, 2'h0);
      rd_chk("off_read", 4'h0, 32'h04);
      wr(4'h0, 32'h81);
      settle();
      rd_chk("reenable", 4'h0, 32'hA9);
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      rd_chk("ctrl_rerst", 4'h0, 32'h0);
      rd_chk("sticky_rerst", 4'h4, 32'h0);
      stop_test();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      stop_test();
   end
endmodule // analog_comparator_control_tb_top
